/* shared/moc_regs.svh */
// Register map, reset values and limits of the measurement output conditioning block.
`ifndef MOC_REGS_SVH
`define MOC_REGS_SVH
`define MOC_OFS_CTRL      8'h00
`define MOC_OFS_WINDOW    8'h04
`define MOC_OFS_INTERVAL  8'h08
`define MOC_OFS_VMAX      8'h0c
`define MOC_OFS_VMIN      8'h10
`define MOC_OFS_AO_LOW    8'h14
`define MOC_OFS_AO_HIGH   8'h18
`define MOC_OFS_AO_QTY    8'h1c
`define MOC_OFS_DISTANCE  8'h20
`define MOC_OFS_STATUS    8'h24
`define MOC_OFS_AVG_FREQ  8'h28
`define MOC_OFS_LENGTH    8'h2c
`define MOC_CTRL_AO_EN    0
`define MOC_CTRL_TRIG_EN  1
`define MOC_CTRL_TRIG_INV 2
`define MOC_CTRL_SRC_LSB  8
`define MOC_ST_RUN        0
`define MOC_ST_CLOSED     1
`define MOC_ST_YELLOW     2
`define MOC_ST_ERR        3
`define MOC_RST_CTRL      32'h0000_0000
`define MOC_RST_WINDOW    6'h01
`define MOC_RST_INTERVAL  32'h0003_d090
`define MOC_RST_VMAX      32'h0000_2710
`define MOC_RST_VMIN      32'h0000_0000
`define MOC_RST_AO_LOW    32'h0000_0000
`define MOC_RST_AO_HIGH   32'h0000_2710
`define MOC_VMAX_MIN      32'sh0000_0001
`define MOC_VMAX_MAX      32'sh0000_2710
`define MOC_VMIN_MAX      32'sh0000_2710
`define MOC_AO_LIMIT      32'sh0001_86a0
`define MOC_WINDOW_MAX    6'h20
`define MOC_QTY_V         8'h56
`define MOC_QTY_R         8'h52
`define MOC_QTY_Q         8'h51
`define MOC_RATE_SCALE    32'sh0000_0064
`define MOC_DAC_LOW       16'h0000
`define MOC_DAC_HIGH      16'hffff
`endif

/* shared/moc_pkg.sv */
// Types shared by the measurement output conditioning block.
package moc_pkg;
    typedef enum logic [1:0] {
        TRIG_IDLE = 2'b01,
        TRIG_RUN  = 2'b10
    } trig_state_e;
    typedef enum logic [1:0] {
        SRC_INTERVAL = 2'h0,
        SRC_TRIGGER  = 2'h1,
        SRC_BURST    = 2'h2
    } update_src_e;
endpackage

/* design/measurement_output_conditioning.sv */
// Trigger, averager, velocity suppression and current output logic with APB registers.
`timescale 1ns/1ps
`include "moc_regs.svh"
module measurement_output_conditioning (
    // Clock and reset.
    input  wire logic               clk_sys_i,
    input  wire logic               sys_rst_i,
    // APB slave.
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic                    pready_o,
    output logic [31:0]             prdata_o,
    output logic                    pslverr_o,
    // Light barriers.
    input  wire logic               stop_barrier_i,
    input  wire logic               start_barrier_input_i,
    // Measurement core.
    input  wire logic               burst_valid_i,
    input  wire logic [15:0]        burst_freq_i,
    input  wire logic [7:0]         burst_quality_i,
    input  wire logic signed [15:0] velocity_i,
    input  wire logic [15:0]        rate_i,
    input  wire logic [7:0]         brightness_i,
    input  wire logic [7:0]         exposure_i,
    input  wire logic               signal_ok_i,
    input  wire logic               velocity_detected_i,
    input  wire logic [31:0]        length_i,
    // Results.
    output logic                    meas_run_o,
    output logic [31:0]             length_out_o,
    output logic                    length_valid_o,
    output logic [15:0]             avg_freq_o,
    output logic                    avg_valid_o,
    output logic                    outputs_closed_o,
    output logic                    led_yellow_o,
    // Current loop converter.
    output logic [15:0]             dac_code_o,
    output logic                    dac_load_o,
    output logic                    current_out_active_o
);
    // Signed range test used for every limited setting except the quantity select.
    function automatic logic in_range(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Register storage.
    logic [31:0] ctrl, next_ctrl, interval, next_interval, vmax, next_vmax;
    logic [31:0] vmin, next_vmin, ao_low, next_ao_low, ao_high, next_ao_high;
    logic [31:0] distance, next_distance;
    logic [7:0]  current_out_quantity_select, next_qty;
    logic [5:0]  window, next_window;
    logic        err_flag, next_err_flag, win_clear, next_win_clear;
    logic        next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic        wr_acc, setup, bad_val;
    logic        current_out_enable, trig_en, trig_inv;
    logic [1:0]  current_out_update_source;

    assign current_out_enable        = ctrl[`MOC_CTRL_AO_EN];
    assign trig_en                   = ctrl[`MOC_CTRL_TRIG_EN];
    assign trig_inv                  = ctrl[`MOC_CTRL_TRIG_INV];
    assign current_out_update_source = ctrl[`MOC_CTRL_SRC_LSB+1:`MOC_CTRL_SRC_LSB];
    assign setup  = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;

    // Value checks are made in the setup phase so the error answer is ready at the access.
    always_comb begin
        case (paddr_i)
            `MOC_OFS_WINDOW:  bad_val = !in_range(pwdata_i, 32'sd1, 32'sd32);
            `MOC_OFS_VMAX:    bad_val = !in_range(pwdata_i, `MOC_VMAX_MIN, `MOC_VMAX_MAX);
            `MOC_OFS_VMIN:    bad_val = !in_range(pwdata_i, 32'sd0, `MOC_VMIN_MAX);
            `MOC_OFS_AO_LOW,
            `MOC_OFS_AO_HIGH: bad_val = !in_range(pwdata_i, -`MOC_AO_LIMIT, `MOC_AO_LIMIT);
            `MOC_OFS_AO_QTY:  bad_val = !(pwdata_i[7:0] == `MOC_QTY_V ||
                                          pwdata_i[7:0] == `MOC_QTY_R ||
                                          pwdata_i[7:0] == `MOC_QTY_Q);
            default:          bad_val = 1'b0;
        endcase
    end

    // Register writes, read mux and the zero-wait-state APB answer.
    always_comb begin
        next_ctrl     = ctrl;
        next_window   = window;
        next_interval = interval;
        next_vmax     = vmax;
        next_vmin     = vmin;
        next_ao_low   = ao_low;
        next_ao_high  = ao_high;
        next_qty      = current_out_quantity_select;
        next_distance = distance;
        next_err_flag = err_flag;
        next_win_clear = 1'b0;
        next_pready   = setup;
        next_pslverr  = 1'b0;
        next_prdata   = 32'h0000_0000;
        if (setup) begin
            case (paddr_i)
                `MOC_OFS_CTRL:     next_prdata = ctrl;
                `MOC_OFS_WINDOW:   next_prdata = {26'h0, window};
                `MOC_OFS_INTERVAL: next_prdata = interval;
                `MOC_OFS_VMAX:     next_prdata = vmax;
                `MOC_OFS_VMIN:     next_prdata = vmin;
                `MOC_OFS_AO_LOW:   next_prdata = ao_low;
                `MOC_OFS_AO_HIGH:  next_prdata = ao_high;
                `MOC_OFS_AO_QTY:   next_prdata = {24'h0, current_out_quantity_select};
                `MOC_OFS_DISTANCE: next_prdata = distance;
                `MOC_OFS_STATUS:   next_prdata = {28'h0, err_flag, led_yellow_o,
                                                  outputs_closed_o, meas_run_o};
                `MOC_OFS_AVG_FREQ: next_prdata = {16'h0, avg_freq_o};
                `MOC_OFS_LENGTH:   next_prdata = length_out_o;
                default:           next_pslverr = 1'b1;
            endcase
            if (pwrite_i && bad_val) begin
                next_pslverr = 1'b1;
            end
        end
        if (wr_acc && !pslverr_o) begin
            case (paddr_i)
                `MOC_OFS_CTRL:     next_ctrl = pwdata_i & 32'h0000_0307;
                `MOC_OFS_WINDOW: begin
                    next_window    = pwdata_i[5:0];
                    next_win_clear = 1'b1;
                end
                `MOC_OFS_INTERVAL: next_interval = (pwdata_i == 32'h0) ? 32'h1 : pwdata_i;
                `MOC_OFS_VMAX:     next_vmax = pwdata_i;
                `MOC_OFS_VMIN: begin
                    next_vmin = pwdata_i;
                    if (pwdata_i != 32'h0 && pwdata_i >= vmax) begin
                        next_err_flag = 1'b1;
                    end
                end
                `MOC_OFS_AO_LOW:   next_ao_low = pwdata_i;
                `MOC_OFS_AO_HIGH:  next_ao_high = pwdata_i;
                `MOC_OFS_AO_QTY:   next_qty = pwdata_i[7:0];
                `MOC_OFS_DISTANCE: next_distance = pwdata_i;
                `MOC_OFS_STATUS: begin
                    if (pwdata_i[`MOC_ST_ERR]) begin
                        next_err_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl      <= `MOC_RST_CTRL;
            window    <= `MOC_RST_WINDOW;
            interval  <= `MOC_RST_INTERVAL;
            vmax      <= `MOC_RST_VMAX;
            vmin      <= `MOC_RST_VMIN;
            ao_low    <= `MOC_RST_AO_LOW;
            ao_high   <= `MOC_RST_AO_HIGH;
            current_out_quantity_select <= `MOC_QTY_V;
            distance  <= 32'h0000_0000;
            err_flag  <= 1'b0;
            win_clear <= 1'b0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            ctrl      <= next_ctrl;
            window    <= next_window;
            interval  <= next_interval;
            vmax      <= next_vmax;
            vmin      <= next_vmin;
            ao_low    <= next_ao_low;
            ao_high   <= next_ao_high;
            current_out_quantity_select <= next_qty;
            distance  <= next_distance;
            err_flag  <= next_err_flag;
            win_clear <= next_win_clear;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
            prdata_o  <= next_prdata;
        end
    end

    // Averaging interval divider; the tick is the only slower rate in the block.
    logic [31:0] int_cnt, next_int_cnt;
    logic        tick;
    assign tick = (int_cnt >= interval - 32'h1);
    assign next_int_cnt = tick ? 32'h0 : int_cnt + 32'h1;

    // Two-barrier trigger; inversion flips every level so edges flip too.
    moc_pkg::trig_state_e state, next_state;
    logic s_now, t_now, s_q, t_q, start_ev, stop_ev;
    assign s_now = stop_barrier_i ^ trig_inv;
    assign t_now = start_barrier_input_i ^ trig_inv;
    always_comb begin
        next_state = state;
        start_ev   = 1'b0;
        stop_ev    = 1'b0;
        case (state)
            moc_pkg::TRIG_IDLE: begin
                if (trig_en && s_q && !t_q && s_now && t_now) begin
                    start_ev   = 1'b1;
                    next_state = moc_pkg::TRIG_RUN;
                end
            end
            moc_pkg::TRIG_RUN: begin
                if (!trig_en) begin
                    next_state = moc_pkg::TRIG_IDLE;
                end else if (s_q && t_q && !s_now && t_now) begin
                    stop_ev    = 1'b1;
                    next_state = moc_pkg::TRIG_IDLE;
                end else if (!(s_now && t_now)) begin
                    // Leaving the sequence any other way drops the run with no stop event.
                    next_state = moc_pkg::TRIG_IDLE;
                end
            end
            default: next_state = moc_pkg::TRIG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state          <= moc_pkg::TRIG_IDLE;
            s_q            <= 1'b0;
            t_q            <= 1'b0;
            int_cnt        <= 32'h0;
            meas_run_o     <= 1'b0;
            length_out_o   <= 32'h0;
            length_valid_o <= 1'b0;
        end else begin
            state          <= next_state;
            s_q            <= s_now;
            t_q            <= t_now;
            int_cnt        <= next_int_cnt;
            meas_run_o     <= (next_state == moc_pkg::TRIG_RUN);
            length_valid_o <= stop_ev;
            if (stop_ev) begin
                length_out_o <= length_i + distance;
            end
        end
    end

    // Sliding averager: slot sums land in a ring, the window total adds the new
    // slot and drops the one written window ticks ago. The combinational divide
    // costs area but keeps the result ready in the tick cycle.
    logic [31:0] ring_w [32];
    logic [31:0] ring_q [32];
    logic [31:0] cur_w, cur_q, next_cur_w, next_cur_q, in_w, in_q;
    logic [36:0] tot_w, tot_q, next_tot_w, next_tot_q;
    logic [4:0]  wp, old_idx;
    logic [15:0] next_avg;
    // Each factor is widened first, so the full 24-bit product survives the concatenation.
    assign in_w    = burst_valid_i ? {8'h0, 24'(burst_freq_i) * 24'(burst_quality_i)} : 32'h0;
    assign in_q    = burst_valid_i ? {24'h0, burst_quality_i} : 32'h0;
    assign old_idx = wp - window[4:0];
    always_comb begin
        next_tot_w = tot_w;
        next_tot_q = tot_q;
        next_cur_w = cur_w + in_w;
        next_cur_q = cur_q + in_q;
        next_avg   = avg_freq_o;
        if (tick) begin
            next_tot_w = tot_w + {5'h0, cur_w} - {5'h0, ring_w[old_idx]};
            next_tot_q = tot_q + {5'h0, cur_q} - {5'h0, ring_q[old_idx]};
            next_cur_w = in_w;
            next_cur_q = in_q;
            next_avg   = (next_tot_q == 37'h0) ? 16'h0 : 16'(next_tot_w / next_tot_q);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || win_clear) begin
            for (int i = 0; i < 32; i++) begin
                ring_w[i] <= 32'h0;
                ring_q[i] <= 32'h0;
            end
            cur_w       <= 32'h0;
            cur_q       <= 32'h0;
            tot_w       <= 37'h0;
            tot_q       <= 37'h0;
            wp          <= 5'h0;
            avg_freq_o  <= 16'h0;
            avg_valid_o <= 1'b0;
        end else begin
            if (tick) begin
                ring_w[wp] <= cur_w;
                ring_q[wp] <= cur_q;
                wp         <= wp + 5'h1;
            end
            cur_w       <= next_cur_w;
            cur_q       <= next_cur_q;
            tot_w       <= next_tot_w;
            tot_q       <= next_tot_q;
            avg_freq_o  <= next_avg;
            avg_valid_o <= tick;
        end
    end

    // Minimum velocity suppression and indicator.
    logic [15:0] vabs;
    logic        below;
    assign vabs  = velocity_i[15] ? 16'(-velocity_i) : velocity_i;
    assign below = (vmin != 32'h0) && ({16'h0, vabs} < vmin);

    // Current output: pick the quantity, scale between low and high, clamp.
    logic signed [31:0] qty, lo, hi;
    logic signed [49:0] num, span;
    logic signed [49:0] scaled;
    logic [15:0]        code, next_code;
    logic               upd, closed_now;
    assign lo = ao_low;
    assign hi = ao_high;
    always_comb begin
        case (current_out_quantity_select)
            `MOC_QTY_V: qty = 32'(velocity_i);
            `MOC_QTY_R: qty = $signed({16'h0, rate_i}) * `MOC_RATE_SCALE;
            default: begin
                qty = signal_ok_i ? $signed({16'h0, rate_i}) * `MOC_RATE_SCALE
                                  : $signed({16'h0, 16'(brightness_i) * 16'(exposure_i)});
            end
        endcase
        span = 50'(hi) - 50'(lo);
        num  = (50'(qty) - 50'(lo)) * 50'(`MOC_DAC_HIGH - `MOC_DAC_LOW);
        scaled = (span == 50'sh0) ? 50'sh0 : num / span;
        if (scaled <= 50'sh0) begin
            code = `MOC_DAC_LOW;
        end else if (scaled >= 50'(`MOC_DAC_HIGH - `MOC_DAC_LOW)) begin
            code = `MOC_DAC_HIGH;
        end else begin
            code = `MOC_DAC_LOW + scaled[15:0];
        end
    end

    always_comb begin
        case (moc_pkg::update_src_e'(current_out_update_source))
            moc_pkg::SRC_INTERVAL: upd = tick;
            moc_pkg::SRC_TRIGGER:  upd = stop_ev;
            moc_pkg::SRC_BURST:    upd = burst_valid_i;
            default:               upd = tick;
        endcase
        closed_now = signal_ok_i && below;
        next_code  = dac_code_o;
        if (!current_out_enable || closed_now) begin
            next_code = `MOC_DAC_LOW;
        end else if (upd) begin
            next_code = code;
        end
    end

    // Closing acts in the same cycle as the drop, with no hold time.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            dac_code_o           <= `MOC_DAC_LOW;
            dac_load_o           <= 1'b0;
            current_out_active_o <= 1'b0;
            outputs_closed_o     <= 1'b0;
            led_yellow_o         <= 1'b0;
        end else begin
            dac_code_o           <= next_code;
            dac_load_o           <= current_out_enable && (upd || closed_now);
            current_out_active_o <= current_out_enable;
            outputs_closed_o     <= closed_now;
            led_yellow_o         <= velocity_detected_i && below;
        end
    end
endmodule

/* dv/measurement_output_conditioning_checker.sv */
// Port-level assertion checker for the measurement output conditioning block.
`timescale 1ns/1ps
module measurement_output_conditioning_checker (
    // Clock, reset and APB handshake.
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Barriers and measurement results.
    input wire logic        stop_barrier_i,
    input wire logic        start_barrier_input_i,
    input wire logic        velocity_detected_i,
    input wire logic        meas_run_o,
    input wire logic        length_valid_o,
    input wire logic        led_yellow_o,
    // Converter side.
    input wire logic [15:0] dac_code_o,
    input wire logic        current_out_active_o
);
    // One clock domain, so clock and reset are stated once for every property.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // The slave answers in the cycle right after the setup cycle.
    apb_answer_a: assert property (
        psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
    ready_in_access_a: assert property (
        pready_o |-> psel_i && penable_i) else $error("ready outside access");
    error_with_ready_a: assert property (
        pslverr_o |-> pready_o) else $error("error without ready");
    // Polarity-neutral form, so the inverted setting is covered too.
    run_start_edge_a: assert property (
        $rose(meas_run_o) |-> $past(start_barrier_input_i) != $past(start_barrier_input_i, 2)
        && $past(stop_barrier_i) == $past(stop_barrier_i, 2)
        && $past(stop_barrier_i, 2) != $past(start_barrier_input_i, 2))
        else $error("run began without a start edge");
    stop_edge_a: assert property (
        length_valid_o |-> $past(stop_barrier_i) != $past(stop_barrier_i, 2)
        && $past(start_barrier_input_i) == $past(start_barrier_input_i, 2))
        else $error("length result without a stop edge");
    stop_ends_run_a: assert property (
        length_valid_o |-> !meas_run_o && $past(meas_run_o)) else $error("stop did not end run");
    off_code_zero_a: assert property (
        !current_out_active_o && $past(current_out_active_o) == 1'b0 |-> dac_code_o == 16'h0000)
        else $error("converter code while output off");
    yellow_cause_a: assert property (
        led_yellow_o |-> $past(velocity_detected_i)) else $error("yellow without velocity");
    cover property ($rose(meas_run_o));
    cover property (length_valid_o);
    cover property (pslverr_o);
endmodule

bind measurement_output_conditioning measurement_output_conditioning_checker i_chk (.*);

/* dv/current_loop_dac.sv */
// Behavioural current loop converter that sits behind the block's converter port.
`timescale 1ns/1ps
module current_loop_dac (
    // Clock and converter port.
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] dac_code_i,
    input  wire logic        dac_load_i,
    // Loop current in microamperes.
    output int               loop_ua_o
);
    // The code is taken only on a load pulse; between loads the loop holds its last current.
    initial loop_ua_o = 4000;
    always @(posedge clk_sys_i) begin
        if (dac_load_i === 1'b1) begin
            loop_ua_o <= 4000 + int'(dac_code_i) * 16000 / 65535;
        end
    end
endmodule

/* dv/test_measurement_output_conditioning.sv */
// Self-checking bench for the measurement output conditioning block.
`timescale 1ns/1ps
`include "moc_regs.svh"
module test_measurement_output_conditioning;
    logic               clk_sys_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic               stop_barrier_i, start_barrier_input_i, burst_valid_i, signal_ok_i;
    logic               velocity_detected_i, meas_run_o, length_valid_o, avg_valid_o;
    logic               outputs_closed_o, led_yellow_o, dac_load_o, current_out_active_o;
    logic [7:0]         paddr_i, burst_quality_i, brightness_i, exposure_i;
    logic [15:0]        burst_freq_i, rate_i, avg_freq_o, dac_code_o;
    logic signed [15:0] velocity_i;
    logic [31:0]        pwdata_i, prdata_o, length_i, length_out_o, rd;
    logic               bursting, ph, inv, er;
    int                 err_count, tests_run, loop_ua, k;
    // Current output table: quantity, velocity, low, high and expected code.
    logic [7:0]         tq[6] = '{8'h56, 8'h56, 8'h56, 8'h56, 8'h52, 8'h51};
    logic signed [15:0] tv[6] = '{16'sh1d4c, 16'sh4e20, -16'sh0064, 16'sh09c4, 16'sh0, 16'sh0};
    logic [31:0]        tl[6] = '{32'h0, 32'h0, 32'h0, 32'h2710, 32'h0, 32'h0};
    logic [31:0]        th[6] = '{32'h2710, 32'h2710, 32'h2710, 32'h0, 32'h2710, 32'h2710};
    logic [15:0]        te[6] = '{16'hbfff, 16'hffff, 16'h0000, 16'hbfff, 16'h3fff, 16'h3333};

    measurement_output_conditioning i_dut (.*);
    current_loop_dac i_dac (.clk_sys_i, .dac_code_i(dac_code_o), .dac_load_i(dac_load_o),
                            .loop_ua_o(loop_ua));

    // Free-running 25 MHz system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // Alternating bursts of two weights, so a plain mean and a weighted mean differ.
    always @(posedge clk_sys_i) begin
        ph <= ~ph;
        burst_valid_i <= bursting;
        burst_freq_i <= ph ? 16'h00c8 : 16'h0064;
        burst_quality_i <= ph ? 8'h03 : 8'h01;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk(32'(er), 32'(e));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] want, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, want);
        chk(32'(er), 32'(e));
    endtask

    // Barrier levels change at least three cycles apart, well above the minimum spacing.
    task automatic bar(input logic s, input logic t);
        @(posedge clk_sys_i);
        stop_barrier_i <= s ^ inv;
        start_barrier_input_i <= t ^ inv;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic burst_run(input int n);
        bursting <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        bursting <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic close_out;
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang is cut off far beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        close_out();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, burst_valid_i, ph, inv} = '0;
        {stop_barrier_i, start_barrier_input_i, signal_ok_i, velocity_detected_i} = '0;
        {bursting, velocity_i, burst_freq_i, burst_quality_i} = '0;
        rate_i = 16'h0019;
        brightness_i = 8'h14;
        exposure_i = 8'h64;
        length_i = 32'h0000_03e8;
        err_count = 0;
        tests_run = 0;
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rdc(`MOC_OFS_VMIN, 32'h0, 1'b0);
        rdc(`MOC_OFS_VMAX, `MOC_RST_VMAX, 1'b0);
        rdc(`MOC_OFS_AO_QTY, 32'h56, 1'b0);
        rdc(8'h3c, 32'h0, 1'b1);
        wrc(`MOC_OFS_WINDOW, 32'h21, 1'b1);
        rdc(`MOC_OFS_WINDOW, 32'h1, 1'b0);
        wrc(`MOC_OFS_VMAX, 32'h0, 1'b1);
        wrc(`MOC_OFS_AO_LOW, 32'hfffe_7960, 1'b0);
        wrc(`MOC_OFS_AO_HIGH, 32'h0001_86a1, 1'b1);
        wrc(`MOC_OFS_AO_LOW, 32'h0, 1'b0);
        wrc(`MOC_OFS_DISTANCE, 32'h35, 1'b0);
        velocity_i <= 16'sh1388;
        // Normal, then inverted barriers: a wrong order first, then the proper sequence.
        for (k = 0; k < 2; k++) begin
            inv = k[0];
            wrc(`MOC_OFS_CTRL, 32'h0000_0103 | {29'h0, k[0], 2'b00}, 1'b0);
            bar(1'b0, 1'b0);
            bar(1'b0, 1'b1);
            bar(1'b1, 1'b1);
            chk(32'(meas_run_o), 32'h0);
            bar(1'b0, 1'b0);
            bar(1'b1, 1'b0);
            bar(1'b1, 1'b1);
            chk(32'(meas_run_o), 32'h1);
            bar(1'b0, 1'b1);
            chk(32'(length_valid_o), 32'h1);
            chk(length_out_o, 32'h0000_041d);
            chk(32'(dac_load_o), 32'h1);
            chk(32'(dac_code_o), 32'h7fff);
        end
        wrc(`MOC_OFS_CTRL, 32'h0000_0100, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        chk(32'(current_out_active_o), 32'h0);
        chk(32'(dac_code_o), 32'h0);
        // Per-burst refresh over every quantity, clamping and a reversed range.
        wrc(`MOC_OFS_CTRL, 32'h0000_0201, 1'b0);
        for (k = 0; k < 6; k++) begin
            wrc(`MOC_OFS_AO_QTY, 32'(tq[k]), 1'b0);
            wrc(`MOC_OFS_AO_LOW, tl[k], 1'b0);
            wrc(`MOC_OFS_AO_HIGH, th[k], 1'b0);
            velocity_i <= tv[k];
            burst_run(3);
            chk(32'(dac_code_o), 32'(te[k]));
            chk(loop_ua, 4000 + int'(te[k]) * 16000 / 65535);
        end
        // Slow movement under a minimum that also clashes with the ceiling.
        signal_ok_i <= 1'b1;
        velocity_detected_i <= 1'b1;
        velocity_i <= 16'sh0032;
        wrc(`MOC_OFS_VMAX, 32'h32, 1'b0);
        apb(1'b1, `MOC_OFS_VMIN, 32'h64);
        burst_run(3);
        rdc(`MOC_OFS_STATUS, 32'he, 1'b0);
        chk(32'(dac_code_o), 32'h0);
        wrc(`MOC_OFS_STATUS, 32'h8, 1'b0);
        wrc(`MOC_OFS_VMIN, 32'h0, 1'b0);
        burst_run(3);
        rdc(`MOC_OFS_STATUS, 32'h0, 1'b0);
        chk(32'(dac_code_o), 32'h3fff);
        // Weighted sliding average over two slots of eight cycles, output refreshed per slot.
        wrc(`MOC_OFS_CTRL, 32'h0000_0001, 1'b0);
        wrc(`MOC_OFS_INTERVAL, 32'h8, 1'b0);
        wrc(`MOC_OFS_WINDOW, 32'h2, 1'b0);
        bursting <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        k = 0;
        repeat (32) begin
            @(posedge clk_sys_i);
            if (avg_valid_o === 1'b1) begin
                k++;
            end
            if (dac_load_o === 1'b1) begin
                k += 16;
            end
        end
        chk(32'(k), 32'h44);
        chk(32'(avg_freq_o), 32'h00af);
        bursting <= 1'b0;
        close_out();
    end
endmodule
